/* File: pgcc_pkg.sv */
`default_nettype none
package pgcc_pkg;
  // register addresses
  localparam logic [7:0] PGCC_ADDR_CONFIG = 8'h13;
  localparam logic [7:0] PGCC_ADDR_CLKSRC = 8'h14;
  localparam logic [7:0] PGCC_ADDR_PGSRC = 8'h15;
  localparam logic [7:0] PGCC_ADDR_PGMODE = 8'h16;
  localparam logic [7:0] PGCC_ADDR_FAULT = 8'h17;
  // pin_delay_thermal_config fields
  localparam int PGCC_CFG_STARTUP_RANGE = 6;
  localparam int PGCC_CFG_SHUTDOWN_RANGE = 5;
  localparam int PGCC_CFG_CLK_PIN_FUNC = 4;
  localparam int PGCC_CFG_CLK_PIN_PD = 3;
  localparam int PGCC_CFG_EN_PIN_PD = 2;
  localparam int PGCC_CFG_TWARN_LEVEL = 1;
  localparam int PGCC_CFG_SPREAD = 0;
  localparam logic [7:0] PGCC_CFG_WMASK = 8'h7F;
  // clock_source_control fields
  localparam int PGCC_CLK_PLL_EN = 6;
  localparam int PGCC_CLK_MUST_ZERO = 5;
  localparam logic [7:0] PGCC_CLK_WMASK = 8'h7F;
  localparam logic [4:0] PGCC_FREQ_MAX_CODE = 5'h17;
  localparam int PGCC_FREQ_MSB = 4;
  // power_good_source_control fields
  localparam int PGCC_PGS_POL = 7;
  localparam int PGCC_PGS_OD = 6;
  localparam int PGCC_PGS_LR_WIN = 5;
  localparam int PGCC_PGS_BK_WIN = 4;
  // power_good_mode_control fields
  localparam int PGCC_PGM_THERM = 2;
  localparam int PGCC_PGM_FAULT = 1;
  localparam int PGCC_PGM_MODE = 0;
  localparam logic [7:0] PGCC_PGM_WMASK = 8'h07;
  // defaults after device reset
  localparam logic [7:0] PGCC_RST_CONFIG = 8'h00;
  localparam logic [7:0] PGCC_RST_CLKSRC = 8'h00;
  localparam logic [7:0] PGCC_RST_PGSRC = 8'h00;
  localparam logic [7:0] PGCC_RST_PGMODE = 8'h00;
  localparam logic [3:0] PGCC_RST_FAULT = 4'h0;
  // delay step timing, in microseconds
  localparam int PGCC_STEP_FINE_US = 500;
  localparam int PGCC_STEP_COARSE_US = 1000;
  localparam int PGCC_CLK_MHZ = 20;
  localparam int PGCC_STEP_FINE_CYC = PGCC_STEP_FINE_US * PGCC_CLK_MHZ;
  localparam int PGCC_STEP_COARSE_CYC = PGCC_STEP_COARSE_US * PGCC_CLK_MHZ;
  localparam int PGCC_NUM_RAILS = 4;
  localparam logic [3:0] PGCC_DELAY_CODE_FULL = 4'hF;
  // rail index order: buck0, buck1, linreg0, linreg1
  localparam int PGCC_NUM_BUCKS = 2;
endpackage : pgcc_pkg
`default_nettype wire

/* File: pgcc_rail_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface pgcc_rail_if;
  import pgcc_pkg::*;
  logic [PGCC_NUM_RAILS-1:0] uv_ok;
  logic [PGCC_NUM_RAILS-1:0] ov_ok;
  logic [PGCC_NUM_RAILS-1:0] monitor_en;
  logic lr_window;
  logic bk_window;
  logic [PGCC_NUM_RAILS-1:0] rail_valid;
  modport eval (input uv_ok, ov_ok, monitor_en, lr_window, bk_window, output rail_valid);
  modport ctrl (output uv_ok, ov_ok, monitor_en, lr_window, bk_window, input rail_valid);
endinterface : pgcc_rail_if
`default_nettype wire

/* File: pgcc_rail_eval.sv */
`timescale 1ns/1ns
`default_nettype none
module pgcc_rail_eval
  import pgcc_pkg::*;
(
  pgcc_rail_if.eval rails
);
  genvar g;
  generate
    for (g = 0; g < PGCC_NUM_RAILS; g++) begin : g_rail
      wire logic win_sel;
      assign win_sel = (g < PGCC_NUM_BUCKS) ? rails.bk_window : rails.lr_window;
      assign rails.rail_valid[g] = rails.uv_ok[g] & (rails.ov_ok[g] | ~win_sel);
    end
  endgenerate
endmodule : pgcc_rail_eval
`default_nettype wire

/* File: pgcc_step_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module pgcc_step_timer
  import pgcc_pkg::*;
#(
  parameter int FINE_CYC = PGCC_STEP_FINE_CYC,
  parameter int COARSE_CYC = PGCC_STEP_COARSE_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic coarse_in,
  input wire logic [3:0] code_in,
  output logic busy_out,
  output logic done_out
);
  logic [31:0] cyc_reg;
  logic [3:0] steps_reg;
  logic busy_reg;
  logic done_reg;
  wire logic [31:0] step_len;
  wire logic step_end;
  assign step_len = coarse_in ? 32'(COARSE_CYC - 1) : 32'(FINE_CYC - 1);
  assign step_end = (cyc_reg == step_len);
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      cyc_reg <= 32'h0;
      steps_reg <= 4'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start_in) begin
        cyc_reg <= 32'h0;
        steps_reg <= code_in;
        busy_reg <= (code_in != 4'h0);
        done_reg <= (code_in == 4'h0);
      end else if (busy_reg) begin
        cyc_reg <= step_end ? 32'h0 : cyc_reg + 32'h1;
        if (step_end) begin
          steps_reg <= steps_reg - 4'h1;
          busy_reg <= (steps_reg != 4'h1);
          done_reg <= (steps_reg == 4'h1);
        end
      end
    end
  end
  assign busy_out = busy_reg;
  assign done_out = done_reg;
endmodule : pgcc_step_timer
`default_nettype wire

/* File: pgcc_top.sv */
`timescale 1ns/1ns
`default_nettype none
module pgcc_top
  import pgcc_pkg::*;
#(
  parameter int FINE_CYC = PGCC_STEP_FINE_CYC,
  parameter int COARSE_CYC = PGCC_STEP_COARSE_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_ack_out,
  input wire logic enable_pin_in,
  input wire logic [3:0] rail_uv_ok_in,
  input wire logic [3:0] rail_ov_ok_in,
  input wire logic thermal_flag_in,
  input wire logic ext_clock_pin_in,
  input wire logic ext_clock_present_in,
  input wire logic second_gp_output_level_in,
  input wire logic gated_window_in,
  output logic second_gp_output_out,
  output logic second_gp_output_oe_b_out,
  output logic ext_clock_route_out,
  output logic clock_pin_pulldown_out,
  output logic enable_pin_pulldown_out,
  output logic thermal_warn_threshold_out,
  output logic spread_spectrum_on_out,
  output logic pll_enable_out,
  output logic use_ext_clock_out,
  output logic [4:0] ext_clock_freq_code_out,
  output logic ext_freq_reserved_out,
  output logic ext_clock_event_out,
  output logic power_good_out,
  output logic power_good_oe_b_out,
  output logic power_good_drive_type_out,
  output logic startup_busy_out,
  output logic startup_done_out,
  output logic shutdown_busy_out,
  output logic shutdown_done_out
);
  ////////////////////////////////////////////////////////////////////////
  // register port
  logic [7:0] cfg_reg;
  logic [7:0] clk_reg;
  logic [7:0] pgs_reg;
  logic [7:0] pgm_reg;
  logic [3:0] fault_reg;
  logic [3:0] fault_next;
  logic [7:0] rdata_reg;
  logic ack_reg;
  wire logic wr_cfg;
  wire logic wr_clk;
  wire logic wr_pgs;
  wire logic wr_pgm;
  wire logic wr_fault;
  wire logic [7:0] rd_mux;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  assign wr_cfg = reg_wr_in & hit(reg_addr_in, PGCC_ADDR_CONFIG);
  assign wr_clk = reg_wr_in & hit(reg_addr_in, PGCC_ADDR_CLKSRC);
  assign wr_pgs = reg_wr_in & hit(reg_addr_in, PGCC_ADDR_PGSRC);
  assign wr_pgm = reg_wr_in & hit(reg_addr_in, PGCC_ADDR_PGMODE);
  assign wr_fault = reg_wr_in & hit(reg_addr_in, PGCC_ADDR_FAULT);
  // unmapped addresses read zero and ignore writes
  assign rd_mux = hit(reg_addr_in, PGCC_ADDR_CONFIG) ? cfg_reg :
                  hit(reg_addr_in, PGCC_ADDR_CLKSRC) ? clk_reg :
                  hit(reg_addr_in, PGCC_ADDR_PGSRC) ? pgs_reg :
                  hit(reg_addr_in, PGCC_ADDR_PGMODE) ? pgm_reg :
                  hit(reg_addr_in, PGCC_ADDR_FAULT) ? {4'h0, fault_reg} : 8'h00;

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      cfg_reg <= PGCC_RST_CONFIG;
      clk_reg <= PGCC_RST_CLKSRC;
      pgs_reg <= PGCC_RST_PGSRC;
      pgm_reg <= PGCC_RST_PGMODE;
      rdata_reg <= 8'h00;
      ack_reg <= 1'b0;
    end else begin
      if (wr_cfg) cfg_reg <= reg_wdata_in & PGCC_CFG_WMASK;
      // bit 5 is stored as written; software keeps it clear
      if (wr_clk) clk_reg <= reg_wdata_in & PGCC_CLK_WMASK;
      if (wr_pgs) pgs_reg <= reg_wdata_in;
      if (wr_pgm) pgm_reg <= reg_wdata_in & PGCC_PGM_WMASK;
      if (reg_rd_in) rdata_reg <= rd_mux;
      ack_reg <= reg_wr_in | reg_rd_in;
    end
  end
  assign reg_rdata_out = rdata_reg;
  assign reg_ack_out = ack_reg;

  ////////////////////////////////////////////////////////////////////////
  // pin and clock configuration
  wire logic clk_pin_is_input;
  wire logic pll_on;
  assign clk_pin_is_input = cfg_reg[PGCC_CFG_CLK_PIN_FUNC];
  assign pll_on = clk_reg[PGCC_CLK_PLL_EN];
  // clock pin routing
  // output forced low while the pin is an input, so no stale level leaks out
  assign ext_clock_route_out = clk_pin_is_input;
  assign second_gp_output_out = second_gp_output_level_in & ~clk_pin_is_input;
  assign second_gp_output_oe_b_out = clk_pin_is_input;
  assign clock_pin_pulldown_out = cfg_reg[PGCC_CFG_CLK_PIN_PD];
  assign enable_pin_pulldown_out = cfg_reg[PGCC_CFG_EN_PIN_PD];
  assign thermal_warn_threshold_out = cfg_reg[PGCC_CFG_TWARN_LEVEL];
  assign spread_spectrum_on_out = cfg_reg[PGCC_CFG_SPREAD];
  assign pll_enable_out = pll_on;
  assign ext_clock_freq_code_out = clk_reg[PGCC_FREQ_MSB:0];
  assign ext_freq_reserved_out = (clk_reg[PGCC_FREQ_MSB:0] > PGCC_FREQ_MAX_CODE);

  // presence arrives asynchronously: two-stage sync before use
  logic pres_s1_reg;
  logic pres_s2_reg;
  logic pres_s3_reg;
  logic evt_reg;
  logic use_ext_reg;
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      pres_s1_reg <= 1'b0;
      pres_s2_reg <= 1'b0;
      pres_s3_reg <= 1'b0;
      evt_reg <= 1'b0;
      use_ext_reg <= 1'b0;
    end else begin
      pres_s1_reg <= ext_clock_present_in;
      pres_s2_reg <= pres_s1_reg;
      pres_s3_reg <= pres_s2_reg;
      evt_reg <= pll_on & (pres_s2_reg ^ pres_s3_reg);
      // auto external clock use
      // reserved codes keep the switching clock on the internal oscillator
      use_ext_reg <= pll_on & pres_s2_reg & clk_pin_is_input & ~ext_freq_reserved_out;
    end
  end
  assign use_ext_clock_out = use_ext_reg;
  assign ext_clock_event_out = evt_reg;

  ////////////////////////////////////////////////////////////////////////
  // sequencing delays
  logic en_s1_reg;
  logic en_s2_reg;
  logic en_s3_reg;
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
      en_s3_reg <= 1'b0;
    end else begin
      en_s1_reg <= enable_pin_in;
      en_s2_reg <= en_s1_reg;
      en_s3_reg <= en_s2_reg;
    end
  end
  // enable pulses shorter than a clock period are seen by the timers only if they span a rising clock edge
  wire logic en_rise;
  wire logic en_fall;
  assign en_rise = en_s2_reg & ~en_s3_reg;
  assign en_fall = ~en_s2_reg & en_s3_reg;
  // per-rail delay fields live outside this block: both timers run the full code
  wire logic [3:0] delay_code;
  assign delay_code = PGCC_DELAY_CODE_FULL;

  pgcc_step_timer #(.FINE_CYC(FINE_CYC), .COARSE_CYC(COARSE_CYC)) u_startup (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .start_in(en_rise),
    .coarse_in(cfg_reg[PGCC_CFG_STARTUP_RANGE]),
    .code_in(delay_code),
    .busy_out(startup_busy_out),
    .done_out(startup_done_out)
  );
  pgcc_step_timer #(.FINE_CYC(FINE_CYC), .COARSE_CYC(COARSE_CYC)) u_shutdown (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .start_in(en_fall),
    .coarse_in(cfg_reg[PGCC_CFG_SHUTDOWN_RANGE]),
    .code_in(delay_code),
    .busy_out(shutdown_busy_out),
    .done_out(shutdown_done_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // power-good evaluation
  logic [3:0] uv_s1_reg;
  logic [3:0] uv_s2_reg;
  logic [3:0] ov_s1_reg;
  logic [3:0] ov_s2_reg;
  logic th_s1_reg;
  logic th_s2_reg;
  logic gw_s1_reg;
  logic gw_s2_reg;
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      uv_s1_reg <= 4'h0;
      uv_s2_reg <= 4'h0;
      ov_s1_reg <= 4'h0;
      ov_s2_reg <= 4'h0;
      th_s1_reg <= 1'b0;
      th_s2_reg <= 1'b0;
      gw_s1_reg <= 1'b0;
      gw_s2_reg <= 1'b0;
    end else begin
      uv_s1_reg <= rail_uv_ok_in;
      uv_s2_reg <= uv_s1_reg;
      ov_s1_reg <= rail_ov_ok_in;
      ov_s2_reg <= ov_s1_reg;
      th_s1_reg <= thermal_flag_in;
      th_s2_reg <= th_s1_reg;
      gw_s1_reg <= gated_window_in;
      gw_s2_reg <= gw_s1_reg;
    end
  end

  pgcc_rail_if rails ();
  assign rails.uv_ok = uv_s2_reg;
  assign rails.ov_ok = ov_s2_reg;
  assign rails.monitor_en = pgs_reg[PGCC_NUM_RAILS-1:0];
  assign rails.lr_window = pgs_reg[PGCC_PGS_LR_WIN];
  assign rails.bk_window = pgs_reg[PGCC_PGS_BK_WIN];
  pgcc_rail_eval u_eval (
    .rails(rails)
  );

  wire logic [3:0] rail_fail;
  wire logic live_ok;
  wire logic mode_ok;
  wire logic pg_valid;
  assign rail_fail = rails.monitor_en & ~rails.rail_valid;
  assign live_ok = (rail_fail == 4'h0);
  // gated mode uses window, continuous always evaluates
  assign mode_ok = pgm_reg[PGCC_PGM_MODE] | gw_s2_reg;

  // gated mode: failures outside the window are not latched
  // fault latch set wins clear
  always_comb begin
    fault_next = fault_reg;
    // clear only where the rail is valid now, so a write cannot hide a failing rail
    if (wr_fault) fault_next = fault_reg & ~(reg_wdata_in[PGCC_NUM_RAILS-1:0] & rails.rail_valid);
    fault_next = fault_next | (rail_fail & {4{mode_ok}});
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) fault_reg <= PGCC_RST_FAULT;
    else fault_reg <= fault_next;
  end

  assign pg_valid = mode_ok
                    & (pgm_reg[PGCC_PGM_FAULT] ? (fault_reg == 4'h0) & live_ok : live_ok)
                    & ~(pgm_reg[PGCC_PGM_THERM] & th_s2_reg);

  // registered so the pin never shows a decode glitch
  logic pg_level_reg;
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) pg_level_reg <= 1'b0;
    else pg_level_reg <= pg_valid ^ pgs_reg[PGCC_PGS_POL];
  end
  assign power_good_out = pg_level_reg;
  assign power_good_oe_b_out = pgs_reg[PGCC_PGS_OD] & pg_level_reg;
  assign power_good_drive_type_out = pgs_reg[PGCC_PGS_OD];
endmodule : pgcc_top
`default_nettype wire

/* File: pgcc_top_props.sv */
`timescale 1ns/1ns
`default_nettype none
module pgcc_top_props
  import pgcc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_ack_out,
  input wire logic ext_clock_route_out,
  input wire logic second_gp_output_oe_b_out,
  input wire logic pll_enable_out,
  input wire logic use_ext_clock_out,
  input wire logic [4:0] ext_clock_freq_code_out,
  input wire logic ext_freq_reserved_out,
  input wire logic ext_clock_event_out,
  input wire logic power_good_out,
  input wire logic power_good_oe_b_out,
  input wire logic power_good_drive_type_out,
  input wire logic startup_done_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////
  chk_route_on_write: assert property (
    reg_wr_in && reg_addr_in == PGCC_ADDR_CONFIG |=> ext_clock_route_out == $past(reg_wdata_in[4]))
    else $error("route bit did not follow write");
  chk_gp_release_route: assert property (
    second_gp_output_oe_b_out == ext_clock_route_out) else $error("second output enable wrong");
  chk_clk_rsvd_read: assert property (
    reg_rd_in && reg_addr_in == PGCC_ADDR_CLKSRC |=> reg_ack_out && reg_rdata_out[7] == 1'b0 &&
    reg_rdata_out[PGCC_CLK_MUST_ZERO] == 1'b0) else $error("clock reserved bit read nonzero");
  // one cycle of slack for the registered selection
  chk_pll_off_internal: assert property (
    !pll_enable_out && !$past(pll_enable_out) |-> !use_ext_clock_out) else $error("external clock with pll off");
  chk_rsvd_code_flag: assert property (
    ext_freq_reserved_out == (ext_clock_freq_code_out > PGCC_FREQ_MAX_CODE)) else $error("reserved flag wrong");
  chk_rsvd_code_use: assert property (
    ext_freq_reserved_out && $past(ext_freq_reserved_out) |-> !use_ext_clock_out) else $error("reserved code used");
  chk_event_needs_pll: assert property (
    ext_clock_event_out |-> pll_enable_out || $past(pll_enable_out)) else $error("event with pll off");
  chk_event_one_cycle: assert property (
    ext_clock_event_out |=> !ext_clock_event_out) else $error("event longer than a cycle");
  chk_pushpull_drives: assert property (
    !power_good_drive_type_out && !$past(power_good_drive_type_out) |-> !power_good_oe_b_out)
    else $error("push-pull output released");
  chk_od_releases_high: assert property (
    power_good_drive_type_out && $past(power_good_drive_type_out) && $stable(power_good_out)
    |-> power_good_oe_b_out == power_good_out) else $error("open-drain enable wrong");
  chk_done_single: assert property (
    startup_done_out |=> !startup_done_out) else $error("done longer than a cycle");
endmodule : pgcc_top_props
bind pgcc_top pgcc_top_props u_pgcc_top_props (.core_clk_in, .rst_b_in, .reg_rd_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rdata_out, .reg_ack_out, .ext_clock_route_out,
  .second_gp_output_oe_b_out, .pll_enable_out, .use_ext_clock_out, .ext_clock_freq_code_out,
  .ext_freq_reserved_out, .ext_clock_event_out, .power_good_out, .power_good_oe_b_out,
  .power_good_drive_type_out, .startup_done_out);
`default_nettype wire

/* File: pgcc_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module pgcc_top_bench;
  import pgcc_pkg::*;
  // short step counts keep the run brief
  localparam int FINE = 4;
  localparam int COARSE = 8;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, en = 0, therm = 0, xpres = 0, gplvl = 0, gwin = 1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rdo;
  logic [3:0] uv = 4'h0, ov = 4'h0;
  logic ack, pg, pg_oe_b, pg_od, route, cpd, epd, thr, ssc, pll, use_ext, rsv, evt;
  logic gp, gp_oe_b, su_busy, su_done, sd_busy, sd_done;
  logic [4:0] fcode;
  int num_errors = 0;
  int n_tests = 0;
  pgcc_top #(.FINE_CYC(FINE), .COARSE_CYC(COARSE)) u_pgcc_top (.core_clk_in(clk), .rst_b_in(rst_b),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdo),
    .reg_ack_out(ack), .enable_pin_in(en), .rail_uv_ok_in(uv), .rail_ov_ok_in(ov),
    .thermal_flag_in(therm), .ext_clock_pin_in(1'b0), .ext_clock_present_in(xpres),
    .second_gp_output_level_in(gplvl), .gated_window_in(gwin), .second_gp_output_out(gp),
    .second_gp_output_oe_b_out(gp_oe_b), .ext_clock_route_out(route), .clock_pin_pulldown_out(cpd),
    .enable_pin_pulldown_out(epd), .thermal_warn_threshold_out(thr), .spread_spectrum_on_out(ssc),
    .pll_enable_out(pll), .use_ext_clock_out(use_ext), .ext_clock_freq_code_out(fcode),
    .ext_freq_reserved_out(rsv), .ext_clock_event_out(evt), .power_good_out(pg),
    .power_good_oe_b_out(pg_oe_b), .power_good_drive_type_out(pg_od), .startup_busy_out(su_busy),
    .startup_done_out(su_done), .shutdown_busy_out(sd_busy), .shutdown_done_out(sd_done));
  ////////////////////////////////////////////////////////////
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // one access; ack is looked at in the cycle it stands
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    `CHK(ack, 1'b1)
    rdata = rdo;
    @(posedge clk);
  endtask : acc
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask : wr8
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK(rdata, e)
  endtask : rd8
  // input to pin takes three cycles; five leaves margin
  task automatic pgchk(input logic e);
    cyc(5);
    #1;
    `CHK(pg, e)
    @(posedge clk);
  endtask : pgchk
  task automatic evcnt(input int e);
    int c;
    c = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (evt === 1'b1) c++;
    end
    @(posedge clk);
    `CHK(c, e)
  endtask : evcnt
  // two sync stages and the start edge come before the fifteen steps
  task automatic meas(input logic lvl, input int e);
    int c;
    int b;
    c = 0;
    b = 0;
    en <= lvl;
    do begin
      @(posedge clk);
      #1;
      c++;
      if ((lvl ? su_busy : sd_busy) === 1'b1) b++;
    end while ((lvl ? su_done : sd_done) !== 1'b1 && c < 1000);
    @(posedge clk);
    `CHK(c, e + 3)
    `CHK(b, e)
  endtask : meas
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 8'h13; a <= 8'h18; a++) rd8(8'(a), 8'h00);
    `CHK(pg_oe_b, 1'b0)
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr8(PGCC_ADDR_CONFIG, 8'h80 | 8'(1 << i));
      `CHK({route, cpd, epd, thr, ssc}, 5'(1 << i))
    end
    rd8(PGCC_ADDR_CONFIG, 8'h10);
    `CHK(gp_oe_b, 1'b1)
    wr8(PGCC_ADDR_CONFIG, 8'h08);
    gplvl <= 1'b1;
    cyc(3);
    `CHK({gp_oe_b, gp, cpd}, 3'h3)
    $display("test config done");
    wr8(PGCC_ADDR_CLKSRC, 8'hDF);
    rd8(PGCC_ADDR_CLKSRC, 8'h5F);
    `CHK(rsv, 1'b1)
    wr8(PGCC_ADDR_CONFIG, 8'h10);
    wr8(PGCC_ADDR_CLKSRC, 8'h57);
    `CHK({pll, rsv}, 2'h2)
    `CHK(fcode, 5'h17)
    xpres <= 1'b1;
    evcnt(1);
    `CHK(use_ext, 1'b1)
    wr8(PGCC_ADDR_CLKSRC, 8'h58);
    cyc(2);
    `CHK(use_ext, 1'b0)
    xpres <= 1'b0;
    evcnt(1);
    xpres <= 1'b1;
    cyc(4);
    wr8(PGCC_ADDR_CLKSRC, 8'h17);
    cyc(2);
    `CHK({pll, use_ext}, 2'h0)
    xpres <= 1'b0;
    evcnt(0);
    $display("test clock done");
    uv <= 4'hF;
    wr8(PGCC_ADDR_PGMODE, 8'h01);
    wr8(PGCC_ADDR_PGSRC, 8'h0F);
    pgchk(1'b1);
    wr8(PGCC_ADDR_PGSRC, 8'h1F);
    pgchk(1'b0);
    ov <= 4'h3;
    pgchk(1'b1);
    wr8(PGCC_ADDR_PGSRC, 8'h3F);
    pgchk(1'b0);
    ov <= 4'hF;
    pgchk(1'b1);
    wr8(PGCC_ADDR_PGSRC, 8'h3B);
    uv <= 4'hB;
    pgchk(1'b1);
    wr8(PGCC_ADDR_PGSRC, 8'hBB);
    pgchk(1'b0);
    wr8(PGCC_ADDR_PGSRC, 8'h7B);
    pgchk(1'b1);
    `CHK({pg_od, pg_oe_b}, 2'h3)
    wr8(PGCC_ADDR_PGMODE, 8'h05);
    therm <= 1'b1;
    pgchk(1'b0);
    therm <= 1'b0;
    pgchk(1'b1);
    $display("test power_good done");
    uv <= 4'hF;
    wr8(PGCC_ADDR_PGMODE, 8'h03);
    cyc(4);
    wr8(PGCC_ADDR_FAULT, 8'h0F);
    rd8(PGCC_ADDR_FAULT, 8'h00);
    pgchk(1'b1);
    uv <= 4'hE;
    pgchk(1'b0);
    uv <= 4'hF;
    pgchk(1'b0);
    rd8(PGCC_ADDR_FAULT, 8'h01);
    uv <= 4'hE;
    cyc(4);
    wr8(PGCC_ADDR_FAULT, 8'h01);
    rd8(PGCC_ADDR_FAULT, 8'h01);
    uv <= 4'hF;
    cyc(4);
    wr8(PGCC_ADDR_FAULT, 8'h01);
    rd8(PGCC_ADDR_FAULT, 8'h00);
    pgchk(1'b1);
    $display("test fault done");
    meas(1'b1, 15 * FINE);
    meas(1'b0, 15 * FINE);
    wr8(PGCC_ADDR_CONFIG, 8'h60);
    meas(1'b1, 15 * COARSE);
    meas(1'b0, 15 * COARSE);
    $display("test delay done");
    print_verdict();
  end
  // whole sequence needs about six hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule : pgcc_top_bench
`default_nettype wire
